// file: pwr_evt_count.sv
// power-unit event selection, conditioning and four 48-bit counters
// Functional notes
// - keep three 4-bit tallies: C0, C3, C6
// - code 0x80 adds selected tally per cycle
// - code 0x00 counts enabled clock cycles
// - counting runs on fixed 800 MHz clock
// - codes 1-3 count voltage up/down/change cycles
// - codes 4-7 count strongest upper-limit cycles
// - codes 0x0B-0x0E count frequency band residency
// - codes 0x1E-0x25 count per-core demotions
// - 0x2F phase shedding, 0x32 regulator hot
// - extra bit: freq change, IO, perf limits
// - extra bit: per-core and total transition cycles
// - transition events only while sequencer active
// - plain events add at most one
// - edge detect counts entries, not cycles
// - C0 occupancy accumulates, threshold 5 counts >4
// - threshold plus tally edge counts entries
// - base event qualified by tally threshold
// - band with inverts counts low tally, freq
// - selector 01 C0, 10 C3, 11 C6
// - code bit 7 marks tally events
// - threshold compare, invert, then edge detect
// - 48-bit counters wrap past bit 47
module pwr_evt_count (
  input  wire logic        core_clk,        // fixed-rate counting clock
  input  wire logic        rst,             // async, active high
  // event sources from microcontroller and state machines
  input  wire logic        volt_up,         // voltage rising
  input  wire logic        volt_down,       // voltage falling
  input  wire logic        freq_change,     // frequency transition
  input  wire logic [3:0]  upper_limit,     // thermal,power,os,current
  input  wire logic [1:0]  lower_limit,     // io, perf
  input  wire logic [1:0]  hot_in,          // internal, external hot
  input  wire logic        phase_shed,      // memory phase shedding
  input  wire logic        regulator_hot,   // regulator hot indication
  input  wire logic [7:0]  uncore_ratio,    // uncore freq, 100 MHz units
  input  wire logic [7:0]  demote_pulse,    // per-core demotion
  input  wire logic [7:0]  core_trans,      // per-core transition cycle
  input  wire logic [7:0]  seq_active,      // core_state_sequencer busy
  input  wire logic [7:0]  fv_trans,        // freq/volt portion active
  input  wire logic [7:0]  core_in_c0,      // core state flags
  input  wire logic [7:0]  core_in_c3,
  input  wire logic [7:0]  core_in_c6,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // all state of the block except the two synchroniser stages
  typedef struct packed {
    logic [3:0][31:0]  ctl;        // per-counter control words
    logic [3:0][47:0]  ctr;        // event counters
    logic [3:0]        cmp_q;      // last comparison result per counter
    logic [31:0]       filt;       // band filter
    logic [3:0]        t_c0;       // cores in C0
    logic [3:0]        t_c3;       // cores in C3
    logic [3:0]        t_c6;       // cores in C6
    logic [7:0]        awaddr;     // captured write address
    logic              aw_got;     // write address held
    logic [31:0]       wdata;      // captured write data
    logic [3:0]        wstrb;      // captured strobes
    logic              w_got;      // write data held
    logic              bvalid;     // write answer pending
    logic [1:0]        bresp;      // write answer code
    logic              rvalid;     // read answer pending
    logic [31:0]       rdata;      // read data
    logic [1:0]        rresp;      // read answer code
  } state_s;

  state_s st_ff;                   // registered state
  state_s nxt_st;                  // next state

  // sources synchronised into the counting clock
  logic [76:0] sync1_ff;           // first stage, read only by second
  logic [76:0] sync2_ff;           // second stage
  logic [76:0] raw_in;             // gathered pin inputs

  assign raw_in = {volt_up, volt_down, freq_change, upper_limit,
                   lower_limit, hot_in, phase_shed, regulator_hot,
                   uncore_ratio, demote_pulse, core_trans, seq_active,
                   fv_trans, core_in_c0, core_in_c3, core_in_c6};

  // two-flop synchroniser for every source pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 77'h0;
      sync2_ff <= 77'h0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // named views of the synchronised sources
  logic       s_vup, s_vdn, s_fchg, s_shed, s_rhot;
  logic [3:0] s_upper;
  logic [1:0] s_lower, s_hot;
  logic [7:0] s_ratio, s_demote, s_trans, s_seq, s_fv, s_c0, s_c3, s_c6;
  assign {s_vup, s_vdn, s_fchg, s_upper, s_lower, s_hot, s_shed, s_rhot,
          s_ratio, s_demote, s_trans, s_seq, s_fv, s_c0, s_c3, s_c6}
         = sync2_ff;

  // count of set bits among eight cores
  function automatic logic [3:0] pop8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // per-core transition cycle, hardware sequencer portion only
  logic [7:0] trans_q;
  assign trans_q = s_trans & s_seq & ~s_fv;

  // decode the nine-bit code into a 4-bit increment
  function automatic logic [3:0] decode(input logic [31:0] c,
                                        input logic [31:0] f,
                                        input state_s s);
    logic [7:0] code;
    logic       ext;
    logic       hit;
    logic [7:0] band;
    code = {1'b0, c[pwr_evt_pkg::CTL_EV_LSB +: 7]}; // tally bit kept apart
    ext  = c[pwr_evt_pkg::CTL_EXTRA];
    hit  = 1'b0;
    band = 8'h0;
    if (!ext) begin
      if (code == pwr_evt_pkg::EV_ELAPSED) begin
        hit = 1'b1;
      end else if (code == pwr_evt_pkg::EV_VOLT_UP) begin
        hit = s_vup;
      end else if (code == pwr_evt_pkg::EV_VOLT_DOWN) begin
        hit = s_vdn;
      end else if (code == pwr_evt_pkg::EV_VOLT_CHANGE) begin
        hit = s_vup | s_vdn;
      end else if (code >= pwr_evt_pkg::EV_LIM_THERMAL &&
                   code <= pwr_evt_pkg::EV_LIM_CURRENT) begin
        hit = s_upper[code[1:0]];
      end else if (code == pwr_evt_pkg::EV_HOT_INT ||
                   code == pwr_evt_pkg::EV_HOT_EXT) begin
        hit = s_hot[code[1]];
      end else if (code >= pwr_evt_pkg::EV_BAND0 &&
                   code <= pwr_evt_pkg::EV_BAND3) begin
        band = f[8 * (code - pwr_evt_pkg::EV_BAND0) +: 8];
        hit  = s_ratio >= band;
      end else if (code >= pwr_evt_pkg::EV_DEMOTE0 &&
                   code <= pwr_evt_pkg::EV_DEMOTE7) begin
        hit = s_demote[3'(code - pwr_evt_pkg::EV_DEMOTE0)];
      end else if (code == pwr_evt_pkg::EV_PHASE_SHED) begin
        hit = s_shed;
      end else if (code == pwr_evt_pkg::EV_REG_HOT) begin
        hit = s_rhot;
      end
    end else begin
      if (code == pwr_evt_pkg::EX_FREQ_CHANGE) begin
        hit = s_fchg;
      end else if (code == pwr_evt_pkg::EX_LIM_IO ||
                   code == pwr_evt_pkg::EX_LIM_PERF) begin
        hit = s_lower[code[1]];
      end else if (code >= pwr_evt_pkg::EX_TRANS0 &&
                   code <= pwr_evt_pkg::EX_TRANS7) begin
        hit = trans_q[3'(code - pwr_evt_pkg::EX_TRANS0)];
      end else if (code == pwr_evt_pkg::EX_TRANS_ALL) begin
        hit = |trans_q;
      end
    end
    return {3'h0, hit};
  endfunction

  // pick the tally named by the selector
  function automatic logic [3:0] tally(input logic [1:0] sel,
                                       input state_s s);
    logic [3:0] t;
    t = 4'h0;
    case (sel)
      pwr_evt_pkg::OCC_C0: t = s.t_c0;
      pwr_evt_pkg::OCC_C3: t = s.t_c3;
      pwr_evt_pkg::OCC_C6: t = s.t_c6;
      default:             t = 4'h0;
    endcase
    return t;
  endfunction

  // axi handshakes: accept while not already holding
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

  // next-state logic: counting and register access
  always_comb begin
    logic [31:0] c;
    logic [3:0]  base;
    logic [3:0]  occ;
    logic [4:0]  thr;
    logic        pass;
    logic        occ_ev;
    logic [3:0]  inc;
    logic        do_wr;
    logic [7:0]  a;
    logic [2:0]  ix;
    logic [31:0] m;
    c = 32'h0; base = 4'h0; occ = 4'h0; thr = 5'h0; pass = 1'b0;
    occ_ev = 1'b0; inc = 4'h0; do_wr = 1'b0; a = 8'h0; ix = 3'h0;
    m = 32'h0;
    nxt_st = st_ff;
    // tallies from the per-core state flags
    nxt_st.t_c0 = pop8(s_c0);
    nxt_st.t_c3 = pop8(s_c3);
    nxt_st.t_c6 = pop8(s_c6);
    // condition and count each counter
    for (int k = 0; k < pwr_evt_pkg::NCTR; k++) begin
      c      = st_ff.ctl[k];
      thr    = c[pwr_evt_pkg::CTL_THR_LSB +: 5];
      occ_ev = c[pwr_evt_pkg::CTL_EV_LSB + 7];
      occ    = tally(c[pwr_evt_pkg::CTL_OCC_LSB +: 2], st_ff);
      base   = decode(c, st_ff.filt, st_ff);
      inc    = 4'h0;
      pass   = 1'b0;
      if (occ_ev && c[7:0] == pwr_evt_pkg::EV_OCCUPANCY &&
          !c[pwr_evt_pkg::CTL_EXTRA]) begin
        // pure tally accumulation or threshold on tally
        if (thr == 5'h0) begin
          inc = occ;
        end else begin
          pass = ({1'b0, occ} >= thr) ^ c[pwr_evt_pkg::CTL_OCC_INV];
          if (c[pwr_evt_pkg::CTL_OCC_EDGE]) begin
            inc = {3'h0, pass && !st_ff.cmp_q[k]};
          end else begin
            inc = {3'h0, pass};
          end
        end
      end else begin
        // base event compared against threshold, then optional edge
        pass = (thr == 5'h0) ? base[0]
             : (({1'b0, base} >= thr) ^ c[pwr_evt_pkg::CTL_INV]);
        if (occ_ev && thr != 5'h0) begin
          // tally qualifier on a base event
          // threshold belongs to the tally, invert to the base event
          pass = (base[0] ^ c[pwr_evt_pkg::CTL_INV]) &&
                 (({1'b0, occ} >= thr) ^
                  c[pwr_evt_pkg::CTL_OCC_INV]);
        end
        if (c[pwr_evt_pkg::CTL_EDGE]) begin
          inc = {3'h0, pass && !st_ff.cmp_q[k]};
        end else begin
          inc = {3'h0, pass};
        end
      end
      nxt_st.cmp_q[k] = pass;
      if (c[pwr_evt_pkg::CTL_EN]) begin
        nxt_st.ctr[k] = st_ff.ctr[k] + {44'h0, inc};
      end
    end
    // write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.awaddr = s_axi_awaddr;
      nxt_st.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
      nxt_st.w_got = 1'b1;
    end
    do_wr = st_ff.aw_got && st_ff.w_got;
    if (do_wr) begin
      a  = st_ff.awaddr;
      ix = a[4:2];
      for (int b = 0; b < 4; b++) begin
        m[8 * b +: 8] = {8{st_ff.wstrb[b]}};
      end
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = 2'h0;
      if (a[7:4] == pwr_evt_pkg::A_CTL0[7:4]) begin
        nxt_st.ctl[a[3:2]] = (st_ff.ctl[a[3:2]] & ~m) |
                             (st_ff.wdata & m);
      end else if (a >= pwr_evt_pkg::A_CTR0_LO && a < 8'h30) begin
        if (!a[2]) begin
          nxt_st.ctr[ix[2:1] ^ 2'h2] = {st_ff.ctr[a[4:3] ^ 2'h2][47:32],
            (st_ff.ctr[a[4:3] ^ 2'h2][31:0] & ~m) | (st_ff.wdata & m)};
        end else begin
          nxt_st.ctr[a[4:3] ^ 2'h2][47:32] =
            (st_ff.ctr[a[4:3] ^ 2'h2][47:32] & ~m[15:0]) |
            (st_ff.wdata[15:0] & m[15:0]);
        end
      end else if (a == pwr_evt_pkg::A_FILTER) begin
        nxt_st.filt = (st_ff.filt & ~m) | (st_ff.wdata & m);
      end else if (a == pwr_evt_pkg::A_CLEAR) begin
        // one bit per counter clears it
        for (int k = 0; k < pwr_evt_pkg::NCTR; k++) begin
          if (st_ff.wdata[k]) begin
            nxt_st.ctr[k] = pwr_evt_pkg::CTR_RST;
          end
        end
      end else if (a != pwr_evt_pkg::A_TALLY) begin
        nxt_st.bresp = 2'h2; // unmapped
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      a = s_axi_araddr;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = 2'h0;
      nxt_st.rdata  = 32'h0;
      if (a[7:4] == pwr_evt_pkg::A_CTL0[7:4]) begin
        nxt_st.rdata = st_ff.ctl[a[3:2]];
      end else if (a >= pwr_evt_pkg::A_CTR0_LO && a < 8'h30) begin
        nxt_st.rdata = a[2] ? {16'h0, st_ff.ctr[a[4:3] ^ 2'h2][47:32]}
                            : st_ff.ctr[a[4:3] ^ 2'h2][31:0];
      end else if (a == pwr_evt_pkg::A_FILTER) begin
        nxt_st.rdata = st_ff.filt;
      end else if (a == pwr_evt_pkg::A_TALLY) begin
        nxt_st.rdata = {20'h0, st_ff.t_c6, st_ff.t_c3, st_ff.t_c0};
      end else if (a != pwr_evt_pkg::A_CLEAR) begin
        nxt_st.rresp = 2'h2; // unmapped
      end
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // state register on the fixed-rate clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: pwr_evt_pkg.sv
// package: constants for the power-unit event counting block
package pwr_evt_pkg;
  // event codes, extra select bit clear
  localparam logic [7:0] EV_ELAPSED      = 8'h00;
  localparam logic [7:0] EV_VOLT_UP      = 8'h01;
  localparam logic [7:0] EV_VOLT_DOWN    = 8'h02;
  localparam logic [7:0] EV_VOLT_CHANGE  = 8'h03;
  localparam logic [7:0] EV_LIM_THERMAL  = 8'h04;
  localparam logic [7:0] EV_LIM_CURRENT  = 8'h07;
  localparam logic [7:0] EV_HOT_INT      = 8'h09;
  localparam logic [7:0] EV_HOT_EXT      = 8'h0A;
  localparam logic [7:0] EV_BAND0        = 8'h0B;
  localparam logic [7:0] EV_BAND3        = 8'h0E;
  localparam logic [7:0] EV_DEMOTE0      = 8'h1E;
  localparam logic [7:0] EV_DEMOTE7      = 8'h25;
  localparam logic [7:0] EV_PHASE_SHED   = 8'h2F;
  localparam logic [7:0] EV_REG_HOT      = 8'h32;
  localparam logic [7:0] EV_OCCUPANCY    = 8'h80;
  // event codes, extra select bit set
  localparam logic [7:0] EX_FREQ_CHANGE  = 8'h00;
  localparam logic [7:0] EX_LIM_IO       = 8'h01;
  localparam logic [7:0] EX_LIM_PERF     = 8'h02;
  localparam logic [7:0] EX_TRANS0       = 8'h03;
  localparam logic [7:0] EX_TRANS7       = 8'h0A;
  localparam logic [7:0] EX_TRANS_ALL    = 8'h0B;
  // field positions in the control word
  localparam int CTL_EV_LSB     = 0;
  localparam int CTL_EXTRA      = 8;
  localparam int CTL_OCC_LSB    = 14;
  localparam int CTL_EDGE       = 18;
  localparam int CTL_EN         = 22;
  localparam int CTL_INV        = 23;
  localparam int CTL_THR_LSB    = 24;
  localparam int CTL_OCC_INV    = 30;
  localparam int CTL_OCC_EDGE   = 31;
  // occupancy source selector codes
  localparam logic [1:0] OCC_C0 = 2'h1;
  localparam logic [1:0] OCC_C3 = 2'h2;
  localparam logic [1:0] OCC_C6 = 2'h3;
  // sizes
  localparam int NCTR   = 4;
  localparam int NCORE  = 8;
  localparam int CTR_W  = 48;
  localparam int TALLY_W = 4;
  // reset values
  localparam logic [31:0] CTL_RST   = 32'h0000_0000;
  localparam logic [31:0] FILT_RST  = 32'h0000_0000;
  localparam logic [47:0] CTR_RST   = 48'h0000_0000_0000;
  // register byte offsets
  localparam logic [7:0] A_CTL0     = 8'h00;
  localparam logic [7:0] A_CTR0_LO  = 8'h10;
  localparam logic [7:0] A_CTR0_HI  = 8'h14;
  localparam logic [7:0] A_FILTER   = 8'h30;
  localparam logic [7:0] A_TALLY    = 8'h34;
  localparam logic [7:0] A_CLEAR    = 8'h38;
  // clock rate of the counting domain
  localparam int CLK_MHZ = 800;
endpackage

// file: pwr_evt_count_props.sv
// checker: bus handshake and answer timing of the event counter block
module pwr_evt_count_props (
  input wire logic        core_clk,      // counting clock
  input wire logic        rst,           // async, active high
  input wire logic [7:0]  s_axi_awaddr,  // write address
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,  // read address
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // address and data of a write taken at one edge
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_lat;
    s_wtake |-> !s_axi_bvalid ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer not two cycles after take");
  property p_r_lat;
    s_rtake |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer not one cycle after take");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped before taken");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data moved before taken");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("write accepted while answer pending");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy)
    else $error("read accepted while answer pending");
  property p_unmap_r;
    s_rtake ##0 (s_axi_araddr > pwr_evt_pkg::A_CLEAR) |=> s_axi_rresp == 2'h2;
  endproperty
  a_unmap_r: assert property (p_unmap_r)
    else $error("unmapped read not refused");
  property p_unmap_w;
    s_wtake ##0 (s_axi_awaddr > pwr_evt_pkg::A_CLEAR)
      |-> ##2 s_axi_bresp == 2'h2;
  endproperty
  a_unmap_w: assert property (p_unmap_w)
    else $error("unmapped write not refused");
  property p_tally;
    s_rtake ##0 (s_axi_araddr == pwr_evt_pkg::A_TALLY)
      |=> s_axi_rdata[31:12] == 20'h0;
  endproperty
  a_tally: assert property (p_tally)
    else $error("tally word has bits above three fields");
endmodule
bind pwr_evt_count pwr_evt_count_props u_props (.core_clk, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: pwr_src_model.sv
// partner model: firmware and state machines that drive event sources
module pwr_src_model (
  input  wire logic        core_clk,      // counting clock
  input  wire logic        rst,           // async, active high
  input  wire logic [76:0] pat,           // requested source levels
  output logic             volt_up,
  output logic             volt_down,
  output logic             freq_change,
  output logic [3:0]       upper_limit,
  output logic [1:0]       lower_limit,
  output logic [1:0]       hot_in,
  output logic             phase_shed,
  output logic             regulator_hot,
  output logic [7:0]       uncore_ratio,
  output logic [7:0]       demote_pulse,
  output logic [7:0]       core_trans,
  output logic [7:0]       seq_active,
  output logic [7:0]       fv_trans,
  output logic [7:0]       core_in_c0,
  output logic [7:0]       core_in_c3,
  output logic [7:0]       core_in_c6
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [76:0] src_ff;  // held source levels
  // sources move only just after an edge, like registered firmware
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src_ff <= '0;
    end else begin
      src_ff <= pat;
    end
  end
  // fan the held word out to the individual sources
  assign {core_in_c6, core_in_c3, core_in_c0, fv_trans, seq_active,
          core_trans, demote_pulse, uncore_ratio, regulator_hot,
          phase_shed, hot_in, lower_limit, upper_limit, freq_change,
          volt_down, volt_up} = src_ff;
endmodule

// file: pwr_evt_count_tb.sv
// self-checking bench for the power-unit event counter block
module pwr_evt_count_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // source positions inside the partner pattern
  localparam logic [76:0] UP = 77'h1, DN = UP << 1, FQ = UP << 2;
  localparam logic [76:0] UL = UP << 3, LL = UP << 7, SH = UP << 11;
  localparam logic [76:0] RH = UP << 12, RT = UP << 13, DM = UP << 21;
  localparam logic [76:0] TR = UP << 29, SQ = UP << 37, FV = UP << 45;
  localparam logic [76:0] C0 = UP << 53, C3 = UP << 61, C6 = UP << 69;
  typedef struct { logic [31:0] ctl; logic [76:0] pat; int rate; } row_s;
  // control word without enable, sources, expected count per cycle
  row_s rows [34] = '{
    '{32'h0, 77'h0, 1}, '{32'h1, UP, 1}, '{32'h2, UP, 0}, '{32'h3, DN, 1},
    '{32'h4, UL, 1}, '{32'h7, UL * 8, 1}, '{32'h5, UL, 0},
    '{32'hB, RT * 8'h20, 1}, '{32'hE, RT * 8'h20, 0}, '{32'h1E, DM, 1},
    '{32'h25, DM * 8'h80, 1}, '{32'h1E, DM * 2, 0}, '{32'h2F, SH, 1},
    '{32'h32, RH, 1}, '{32'h8, 77'h1FFF, 0}, '{32'h100, FQ, 1},
    '{32'hA, UP << 10, 1},
    '{32'h101, LL, 1}, '{32'h102, LL, 0}, '{32'h103, TR | SQ, 1},
    '{32'h10A, (TR | SQ) * 8'h80, 1}, '{32'h103, TR, 0},
    '{32'h103, TR | SQ | FV, 0}, '{32'h10B, (TR | SQ) * 8, 1},
    '{32'h4080, C0 * 8'hFF, 8}, '{32'h8080, C3 * 8'h0F, 4},
    '{32'hC080, C6 * 8'h07, 3}, '{32'h0500_4080, C0 * 8'h1F, 1},
    '{32'h0500_4080, C0 * 8'h0F, 0}, '{32'h0500_4083, DN | C0 * 8'h3F, 1},
    '{32'h0500_4083, DN | C0 * 8'h0F, 0},
    '{32'h4480_408B, RT * 8'h10 | C0 * 8'h07, 1},
    '{32'h4480_408B, RT * 8'h20 | C0 * 8'h07, 0},
    '{32'h4480_408B, RT * 8'h10 | C0 * 8'h1F, 0}};
  logic core_clk, rst, volt_up, volt_down, freq_change;
  logic phase_shed, regulator_hot;
  logic [76:0] pat;        // partner command word
  logic [3:0] upper_limit, s_axi_wstrb;
  logic [1:0] lower_limit, hot_in, s_axi_bresp, s_axi_rresp, r;
  logic [7:0] uncore_ratio, demote_pulse, core_trans, seq_active, fv_trans;
  logic [7:0] core_in_c0, core_in_c3, core_in_c6;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dv;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int fail_count, tests_run, cyc, dt;
  pwr_evt_count DUT (.core_clk, .rst, .volt_up, .volt_down, .freq_change,
    .upper_limit, .lower_limit, .hot_in, .phase_shed, .regulator_hot,
    .uncore_ratio, .demote_pulse, .core_trans, .seq_active, .fv_trans,
    .core_in_c0, .core_in_c3, .core_in_c6, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pwr_src_model u_src (.core_clk, .rst, .pat, .volt_up, .volt_down,
    .freq_change, .upper_limit, .lower_limit, .hot_in, .phase_shed,
    .regulator_hot, .uncore_ratio, .demote_pulse, .core_trans,
    .seq_active, .fv_trans, .core_in_c0, .core_in_c3, .core_in_c6);
  // 50 MHz clock and cycle count
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read: t is the cycle at which the address was taken
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output int t);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        t = cyc;
      end
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // program counter k, sample twice with n pulses of hi between
  task automatic run(input int k, input logic [31:0] ctl,
                     input logic [76:0] hi, input logic [76:0] lo,
                     input int n);
    logic [31:0] v1;
    int t1;
    pat <= lo;
    wr(8'(4 * k), ctl | 32'h0040_0000);
    repeat (6) @(posedge core_clk);
    rd(8'(16 + 8 * k), v1, t1);
    repeat (n) begin
      pat <= hi;
      repeat (3) @(posedge core_clk);
      pat <= lo;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    rd(8'(16 + 8 * k), dv, dt);
    dv = dv - v1;
    dt = dt - t1;
  endtask
  // counts and verdict
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
  // main sequence
  initial begin
    {rst, pat, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '1;
    pat = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    {fail_count, tests_run, cyc} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(pwr_evt_pkg::A_CTR0_LO, dv, dt);
    chk(dv, 32'h0);
    wr(pwr_evt_pkg::A_FILTER, 32'h3000_0014);
    foreach (rows[i]) begin
      run(i % 4, rows[i].ctl, 77'h0, rows[i].pat, 0);
      chk(dv, 32'(rows[i].rate * dt));
    end
    run(0, 32'h0104_0003, DN, 77'h0, 4);
    chk(dv, 32'h4);
    run(1, 32'h8500_4080, C0 * 8'h3F, C0 * 8'h03, 3);
    chk(dv, 32'h3);
    pat <= C0 * 8'hFF | C3 * 8'h0F | C6 * 8'h07;
    repeat (6) @(posedge core_clk);
    rd(pwr_evt_pkg::A_TALLY, dv, dt);
    chk(dv, 32'h0000_0348);
    rd(8'h3C, dv, dt);
    chk(32'(r), 32'h2);
    wr(8'h3C, 32'h1);
    chk(32'(r), 32'h2);
    wr(pwr_evt_pkg::A_CTL0, 32'h0);
    wr(pwr_evt_pkg::A_CTR0_LO, 32'hFFFF_FFF0);
    wr(pwr_evt_pkg::A_CTR0_HI, 32'h0000_FFFF);
    wr(pwr_evt_pkg::A_CTL0, 32'h0040_0000);
    repeat (40) @(posedge core_clk);
    rd(pwr_evt_pkg::A_CTR0_HI, dv, dt);
    chk(dv, 32'h0);
    wr(pwr_evt_pkg::A_CTL0, 32'h0);
    wr(pwr_evt_pkg::A_CLEAR, 32'h1);
    rd(pwr_evt_pkg::A_CTR0_LO, dv, dt);
    chk(dv, 32'h0);
    final_report();
  end
endmodule
